/* core/bser_top.sv */
// bridge system and parity error reporter with an ahb-lite register slave
// Contract
// - downstream perr: secondary write target/read initiator, enabled
// - downstream perr on upstream delayed write primary perr
// - posted write perr seen is a serr candidate
// - no parity serr if bridge was target-detector
// - no serr ever without serr enable
// - every serr assertion sets signaled system error
// - forward secondary serr when forward enable set
// - secondary serr sets received system error bit
// - target abort on posted write raises serr
// - master abort on posted write raises serr
// - posted write retry limit discards and raises serr
// - delayed write retry limit discards and raises serr
// - delayed read retry limit raises serr
// - master timeout serr gated by control enable
// - cause register records serr reason
// - per-event disable bits except master timeout
// - primary and secondary locks independent; the code also sets sec_locked from the primary lock when lock_crosses
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "bser_cfg.svh"
module bser_top #(
  parameter logic [31:0] RETRY_LIMIT = `BSER_RETRY_LIMIT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // bus pins
  input wire logic upstream_parity_error_n,
  input wire logic downstream_parity_error_n,
  input wire logic downstream_system_error_in_n,
  input wire logic pri_lock_n,
  input wire logic sec_lock_n,
  // transaction context from the forwarding engine (same clock)
  input wire logic sec_wr_target,
  input wire logic sec_rd_initiator,
  input wire logic sec_parity_bad,
  input wire logic up_dwr_complete,
  input wire logic up_posted_wr,
  input wire logic down_posted_wr,
  input wire logic self_target_detect,
  input wire logic pw_target_abort,
  input wire logic pw_master_abort,
  input wire logic pw_retry,
  input wire logic dw_retry,
  input wire logic dr_retry,
  input wire logic xfer_done,
  input wire logic dt_master_timeout,
  input wire logic lock_crosses,
  // outputs
  output logic system_error_n,
  output logic downstream_parity_error_out_n,
  output logic downstream_parity_error_oe,
  output logic pri_locked,
  output logic sec_locked,
  output logic discard_posted,
  output logic discard_delayed,
  output logic irq
);
  // pin synchronisers: first stage read only by second
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= 5'h1F;
      sync2_r <= 5'h1F;
    end else begin
      sync1_r <= {sec_lock_n, pri_lock_n, downstream_system_error_in_n,
                  downstream_parity_error_n, upstream_parity_error_n};
      sync2_r <= sync1_r;
    end
  end
  logic up_perr;
  logic dn_perr;
  logic sec_serr;
  assign up_perr = ~sync2_r[0];
  assign dn_perr = ~sync2_r[1];
  assign sec_serr = ~sync2_r[2];

  // registers
  logic [5:0] ctrl_r;
  logic [7:0] dis_r;
  logic [7:0] cause_r;
  logic [2:0] stat_r;
  logic [7:0] imask_r;
  logic [31:0] retry_lim_r;

  // ahb address phase capture
  logic wr_pend_r;
  logic [7:0] waddr_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      waddr_r <= haddr;
    end
  end
  logic wr_now;
  assign wr_now = wr_pend_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `BSER_OFF_CTRL: hrdata <= {26'h0, ctrl_r};
        `BSER_OFF_DIS: hrdata <= {24'h0, dis_r};
        `BSER_OFF_CAUSE: hrdata <= {24'h0, cause_r};
        `BSER_OFF_STAT: hrdata <= {29'h0, stat_r};
        `BSER_OFF_IMASK: hrdata <= {24'h0, imask_r};
        `BSER_OFF_RETRY: hrdata <= retry_lim_r;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // zero wait states, always okay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= `BSER_CTRL_RST;
      dis_r <= 8'h00;
      imask_r <= 8'h00;
      retry_lim_r <= RETRY_LIMIT;
    end else if (wr_now) begin
      unique case (waddr_r)
        `BSER_OFF_CTRL: ctrl_r <= hwdata[5:0];
        `BSER_OFF_DIS: dis_r <= hwdata[7:0];
        `BSER_OFF_IMASK: imask_r <= hwdata[7:0];
        `BSER_OFF_RETRY: retry_lim_r <= hwdata;
        default: ;
      endcase
    end
  end
  logic w1c_cause;
  logic w1c_stat;
  assign w1c_cause = wr_now && (waddr_r == `BSER_OFF_CAUSE);
  assign w1c_stat = wr_now && (waddr_r == `BSER_OFF_STAT);

  // retry counters
  function automatic logic [31:0] bump(input logic [31:0] c, input logic rty,
                                       input logic done, input logic hit);
    if (done || hit)
      bump = 32'h0;
    else if (rty)
      bump = c + 32'h1;
    else
      bump = c;
  endfunction
  logic [31:0] pw_cnt_r;
  logic [31:0] dw_cnt_r;
  logic [31:0] dr_cnt_r;
  logic pw_hit;
  logic dw_hit;
  logic dr_hit;
  assign pw_hit = pw_retry && (pw_cnt_r == retry_lim_r - 32'h1);
  assign dw_hit = dw_retry && (dw_cnt_r == retry_lim_r - 32'h1);
  assign dr_hit = dr_retry && (dr_cnt_r == retry_lim_r - 32'h1);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pw_cnt_r <= 32'h0;
      dw_cnt_r <= 32'h0;
      dr_cnt_r <= 32'h0;
    end else begin
      pw_cnt_r <= bump(pw_cnt_r, pw_retry, xfer_done, pw_hit);
      dw_cnt_r <= bump(dw_cnt_r, dw_retry, xfer_done, dw_hit);
      dr_cnt_r <= bump(dr_cnt_r, dr_retry, xfer_done, dr_hit);
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      discard_posted <= 1'b0;
      discard_delayed <= 1'b0;
    end else begin
      discard_posted <= pw_hit;
      discard_delayed <= dw_hit;
    end
  end
  property p_pw_discard;
    @(posedge mclk) disable iff (!rst_n) pw_hit |=> discard_posted;
  endproperty
  a_pw_discard: assert property (p_pw_discard) else $error("posted discard missing");
  property p_dw_discard;
    @(posedge mclk) disable iff (!rst_n) dw_hit |=> discard_delayed;
  endproperty
  a_dw_discard: assert property (p_dw_discard) else $error("delayed discard missing");

  // event vector
  logic par_ev;
  logic [7:0] ev;
  logic [7:0] ev_en;
  logic serr_ev;
  assign par_ev = ((up_perr && up_posted_wr) || (dn_perr && down_posted_wr))
                  && !self_target_detect
                  && ctrl_r[`BSER_C_PERR_PRI] && ctrl_r[`BSER_C_PERR_SEC];
  always_comb begin
    ev = 8'h00;
    ev[`BSER_E_PAR] = par_ev;
    ev[`BSER_E_TABORT] = pw_target_abort;
    ev[`BSER_E_MABORT] = pw_master_abort && ctrl_r[`BSER_C_MABORT_MODE];
    ev[`BSER_E_PWDISC] = pw_hit;
    ev[`BSER_E_DWDISC] = dw_hit;
    ev[`BSER_E_DRFAIL] = dr_hit;
    ev[`BSER_E_MTO] = dt_master_timeout && ctrl_r[`BSER_C_MTO_EN];
    ev[`BSER_E_FWD] = sec_serr && ctrl_r[`BSER_C_FWD_EN];
  end
  // master timeout has no disable bit
  assign ev_en = ev & ~(dis_r & ~(8'h01 << `BSER_E_MTO));
  assign serr_ev = (|ev_en) && ctrl_r[`BSER_C_SERR_EN];
  // a stray disable bit 6 must never hide the timeout event
  property p_mto_nodis;
    @(posedge mclk) disable iff (!rst_n)
      dt_master_timeout && ctrl_r[`BSER_C_MTO_EN] && ctrl_r[`BSER_C_SERR_EN] |-> serr_ev;
  endproperty
  a_mto_nodis: assert property (p_mto_nodis) else $error("timeout serr masked");
  property p_fwd;
    @(posedge mclk) disable iff (!rst_n)
      sec_serr && ctrl_r[`BSER_C_FWD_EN] && ctrl_r[`BSER_C_SERR_EN] && !dis_r[`BSER_E_FWD]
        |-> serr_ev;
  endproperty
  a_fwd: assert property (p_fwd) else $error("secondary serr not forwarded");

  // cause flags: set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n)
      cause_r <= 8'h00;
    else if (serr_ev)
      cause_r <= (cause_r & ~(w1c_cause ? hwdata[7:0] : 8'h00)) | ev_en;
    else if (w1c_cause)
      cause_r <= cause_r & ~hwdata[7:0];
  end

  // serr output pulse machine
  bser_pkg::bser_st_e st_r;
  logic [3:0] pcnt_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= bser_pkg::BSER_IDLE;
      pcnt_r <= 4'h0;
      system_error_n <= 1'b1;
    end else begin
      unique case (st_r)
        bser_pkg::BSER_IDLE: begin
          if (serr_ev) begin
            st_r <= bser_pkg::BSER_ASSERT;
            pcnt_r <= `BSER_PULSE_CYC;
            system_error_n <= 1'b0;
          end
        end
        bser_pkg::BSER_ASSERT: begin
          if (pcnt_r == 4'h1) begin
            st_r <= bser_pkg::BSER_HOLD;
            system_error_n <= 1'b1;
          end
          pcnt_r <= pcnt_r - 4'h1;
        end
        bser_pkg::BSER_HOLD: st_r <= bser_pkg::BSER_IDLE;
        default: st_r <= bser_pkg::BSER_IDLE;
      endcase
    end
  end

  // downstream parity error drive
  logic dperr;
  assign dperr = ((sec_wr_target || sec_rd_initiator) && sec_parity_bad
                  && ctrl_r[`BSER_C_PERR_SEC])
                 || (up_dwr_complete && up_perr && ctrl_r[`BSER_C_PERR_PRI]
                     && ctrl_r[`BSER_C_PERR_SEC]);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      downstream_parity_error_out_n <= 1'b1;
      downstream_parity_error_oe <= 1'b0;
    end else begin
      downstream_parity_error_out_n <= ~dperr;
      downstream_parity_error_oe <= dperr;
    end
  end
  // enable and level must move together or the line floats while low
  property p_dperr_oe;
    @(posedge mclk) disable iff (!rst_n)
      downstream_parity_error_oe == !downstream_parity_error_out_n;
  endproperty
  a_dperr_oe: assert property (p_dperr_oe) else $error("perr enable out of step");

  // status bits
  logic [2:0] st_set;
  assign st_set = {dperr, sec_serr, serr_ev};
  always_ff @(posedge mclk) begin
    if (!rst_n)
      stat_r <= 3'h0;
    else
      stat_r <= (stat_r & ~(w1c_stat ? hwdata[2:0] : 3'h0)) | st_set;
  end

  // lock tracking: secondary also follows the primary lock when lock_crosses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pri_locked <= 1'b0;
      sec_locked <= 1'b0;
    end else begin
      pri_locked <= ~sync2_r[3];
      sec_locked <= ~sync2_r[4] || (lock_crosses && ~sync2_r[3]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(cause_r & imask_r);
  end

  // assertions
  property p_serr_gate;
    @(posedge mclk) disable iff (!rst_n)
      $fell(system_error_n) |-> $past(ctrl_r[`BSER_C_SERR_EN]);
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("serr without enable");
  property p_sig_bit;
    @(posedge mclk) disable iff (!rst_n)
      serr_ev |=> stat_r[`BSER_S_SIG_SERR];
  endproperty
  a_sig_bit: assert property (p_sig_bit) else $error("signaled bit missing");
  property p_rcv;
    @(posedge mclk) disable iff (!rst_n) sec_serr |=> stat_r[`BSER_S_RCV_SERR];
  endproperty
  a_rcv: assert property (p_rcv) else $error("received bit missing");
  sequence s_ev; serr_ev && st_r == bser_pkg::BSER_IDLE; endsequence
  sequence s_low; !system_error_n [*2] ##1 system_error_n; endsequence
  property p_pulse;
    @(posedge mclk) disable iff (!rst_n) s_ev |=> s_low;
  endproperty
  a_pulse: assert property (p_pulse) else $error("serr pulse shape wrong");
  property p_cause;
    @(posedge mclk) disable iff (!rst_n) serr_ev |=> (cause_r & $past(ev_en)) == $past(ev_en);
  endproperty
  a_cause: assert property (p_cause) else $error("cause not recorded");
  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
      !w1c_cause |=> (cause_r & $past(cause_r)) == $past(cause_r);
  endproperty
  a_hold: assert property (p_hold) else $error("cause lost");
  property p_par;
    @(posedge mclk) disable iff (!rst_n)
      ev[`BSER_E_PAR] |-> !self_target_detect && ctrl_r[`BSER_C_PERR_PRI]
        && ctrl_r[`BSER_C_PERR_SEC];
  endproperty
  a_par: assert property (p_par) else $error("parity serr ungated");
  property p_dis;
    @(posedge mclk) disable iff (!rst_n)
      dis_r[`BSER_E_TABORT] |-> !ev_en[`BSER_E_TABORT];
  endproperty
  a_dis: assert property (p_dis) else $error("disable ignored");
  property p_dperr;
    @(posedge mclk) disable iff (!rst_n)
      !downstream_parity_error_out_n |-> $past(ctrl_r[`BSER_C_PERR_SEC]);
  endproperty
  a_dperr: assert property (p_dperr) else $error("perr without response bit");
endmodule

/* core/bser_cfg.svh */
// register offsets, field positions, reset values and timing counts of the error reporter
`ifndef BSER_CFG_SVH
`define BSER_CFG_SVH
`define BSER_OFF_CTRL 8'h00
`define BSER_OFF_DIS 8'h04
`define BSER_OFF_CAUSE 8'h08
`define BSER_OFF_STAT 8'h0C
`define BSER_OFF_IMASK 8'h10
`define BSER_OFF_RETRY 8'h14
// control register fields
`define BSER_C_PERR_PRI 0
`define BSER_C_PERR_SEC 1
`define BSER_C_SERR_EN 2
`define BSER_C_FWD_EN 3
`define BSER_C_MTO_EN 4
`define BSER_C_MABORT_MODE 5
// cause / disable / interrupt field positions
`define BSER_E_PAR 0
`define BSER_E_TABORT 1
`define BSER_E_MABORT 2
`define BSER_E_PWDISC 3
`define BSER_E_DWDISC 4
`define BSER_E_DRFAIL 5
`define BSER_E_MTO 6
`define BSER_E_FWD 7
`define BSER_NEV 8
// status register fields
`define BSER_S_SIG_SERR 0
`define BSER_S_RCV_SERR 1
`define BSER_S_DOWN_PERR 2
`define BSER_CTRL_RST 6'h00
`define BSER_RETRY_LIMIT 32'h0100_0000
`define BSER_PULSE_CYC 4'h2
`endif

/* core/bser_pkg.sv */
// types of the bridge error reporter
package bser_pkg;
  typedef enum logic [1:0] {
    BSER_IDLE = 2'b00,
    BSER_ASSERT = 2'b01,
    BSER_HOLD = 2'b11
  } bser_st_e;
endpackage

/* verification/bser_far_pins.sv */
// far-side bus agents acting on the pulled-up active-low error and lock lines
`timescale 1ns/1ps
module bser_far_pins (
  // requests from the bench, one bit a line
  input wire logic [4:0] drive_low,
  // line levels seen by the bridge
  output logic [4:0] pins_n
);
  // released lines float back to the pull-up, never to the last driven value
  assign pins_n = ~drive_low;
endmodule

/* verification/tb.sv */
// self-checking bench of the bridge error reporter
`timescale 1ns/1ps
`include "bser_cfg.svh"
module tb;
  logic mclk, rst_n, hsel, hwrite, hrdy, hresp, serr_n, pe_n, pe_oe, plk, slk, dp, dd, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [14:0] ctx;
  logic [4:0] req, pins_n;
  logic [1:0] disc;
  int err_total, check_count;
  bser_far_pins u_bser_far_pins (.drive_low(req), .pins_n(pins_n));
  // retry limit cut to 4 so the discard paths are reached quickly
  bser_top #(.RETRY_LIMIT(32'h0000_0004)) u_bser_top (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .upstream_parity_error_n(pins_n[0]),
    .downstream_parity_error_n(pins_n[1]), .downstream_system_error_in_n(pins_n[2]),
    .pri_lock_n(pins_n[3]), .sec_lock_n(pins_n[4]), .pw_target_abort(ctx[0]),
    .pw_master_abort(ctx[1]), .pw_retry(ctx[2]), .dw_retry(ctx[3]), .dr_retry(ctx[4]),
    .dt_master_timeout(ctx[5]), .xfer_done(ctx[6]), .up_posted_wr(ctx[7]),
    .down_posted_wr(ctx[8]), .self_target_detect(ctx[9]), .sec_wr_target(ctx[10]),
    .sec_rd_initiator(ctx[11]), .sec_parity_bad(ctx[12]), .up_dwr_complete(ctx[13]),
    .lock_crosses(ctx[14]), .system_error_n(serr_n), .downstream_parity_error_out_n(pe_n),
    .downstream_parity_error_oe(pe_oe), .pri_locked(plk), .sec_locked(slk),
    .discard_posted(dp), .discard_delayed(dd), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) disc <= rst_n ? (disc | {dd, dp}) : 2'b00;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic clr;
    bus(1'b1, `BSER_OFF_CAUSE, 32'h0000_00FF);
    bus(1'b1, `BSER_OFF_STAT, 32'h0000_0007);
  endtask
  // raise context bits and pins, drop the pulse bits after one cycle, watch the output
  task automatic ev(input logic [14:0] cm, input logic [4:0] pm, input int b,
                    input logic exp, input logic [31:0] st);
    logic hit;
    hit = 1'b0;
    @(posedge mclk);
    ctx <= ctx | cm;
    req <= req | pm;
    @(posedge mclk);
    ctx <= ctx & ~(cm & 15'h007F);
    repeat (8) begin
      @(posedge mclk);
      if (serr_n === 1'b0) hit = 1'b1;
    end
    chk("serr_seen", {31'h0, exp}, {31'h0, hit});
    ctx <= ctx & ~cm;
    req <= req & ~pm;
    repeat (4) @(posedge mclk);
    if (exp) begin
      rdchk(`BSER_OFF_CAUSE, 32'h1 << b, "cause");
      bus(1'b0, `BSER_OFF_STAT, 32'h0000_0000);
      chk("stat", st, rd & 32'h0000_0003);
    end
    clr;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results;
  end
  initial begin
    {ctx, req, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    rst_n = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(`BSER_OFF_CTRL, 32'h0000_0000, "ctrl_rst");
    rdchk(`BSER_OFF_CAUSE, 32'h0000_0000, "cause_rst");
    rdchk(8'h3C, 32'h0000_0000, "unmapped");
    chk("idle", 32'h3, {30'h0, serr_n, pe_n});
    ev(15'h0001, 5'h00, 1, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_003F);
    ev(15'h0001, 5'h00, 1, 1'b1, 32'h1);
    ev(15'h0002, 5'h00, 2, 1'b1, 32'h1);
    ev(15'h0020, 5'h00, 6, 1'b1, 32'h1);
    ev(15'h0000, 5'h04, 7, 1'b1, 32'h3);
    ev(15'h0080, 5'h01, 0, 1'b1, 32'h1);
    ev(15'h0100, 5'h02, 0, 1'b1, 32'h1);
    ev(15'h0280, 5'h01, 0, 1'b0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ev(15'h0040, 5'h00, 0, 1'b0, 32'h0);
      repeat (3) ev(15'h0004 << i, 5'h00, 0, 1'b0, 32'h0);
      ev(15'h0004 << i, 5'h00, 3 + i, 1'b1, 32'h1);
    end
    chk("discards", 32'h3, {30'h0, disc});
    bus(1'b1, `BSER_OFF_DIS, 32'h0000_0002);
    ev(15'h0001, 5'h00, 1, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_DIS, 32'h0000_0040);
    ev(15'h0020, 5'h00, 6, 1'b1, 32'h1);
    bus(1'b1, `BSER_OFF_DIS, 32'h0000_0000);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_002F);
    ev(15'h0020, 5'h00, 6, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_001F);
    ev(15'h0002, 5'h00, 2, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_0037);
    ev(15'h0000, 5'h04, 7, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_003E);
    ev(15'h0080, 5'h01, 0, 1'b0, 32'h0);
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_003D);
    ctx <= 15'h1400;
    repeat (4) @(posedge mclk);
    chk("perr_off", 32'h1, {30'h0, pe_oe, pe_n});
    bus(1'b1, `BSER_OFF_CTRL, 32'h0000_003F);
    repeat (3) @(posedge mclk);
    chk("perr_on", 32'h2, {30'h0, pe_oe, pe_n});
    ctx <= 15'h1000;
    repeat (3) @(posedge mclk);
    chk("perr_idle", 32'h1, {30'h0, pe_oe, pe_n});
    ctx <= 15'h2000;
    req <= 5'h01;
    repeat (5) @(posedge mclk);
    chk("perr_dwr", 32'h2, {30'h0, pe_oe, pe_n});
    ctx <= 15'h0000;
    req <= 5'h08;
    repeat (5) @(posedge mclk);
    chk("locks_pri", 32'h2, {30'h0, plk, slk});
    req <= 5'h10;
    repeat (5) @(posedge mclk);
    chk("locks_sec", 32'h1, {30'h0, plk, slk});
    ctx <= 15'h4000;
    req <= 5'h08;
    repeat (5) @(posedge mclk);
    chk("locks_cross", 32'h3, {30'h0, plk, slk});
    ctx <= 15'h0000;
    req <= 5'h00;
    repeat (4) @(posedge mclk);
    clr;
    bus(1'b1, `BSER_OFF_IMASK, 32'h0000_0002);
    ctx <= 15'h0001;
    @(posedge mclk);
    ctx <= 15'h0000;
    repeat (4) @(posedge mclk);
    chk("irq_set", 32'h1, {31'h0, irq});
    bus(1'b1, `BSER_OFF_CAUSE, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    results;
  end
endmodule
